// *** irqdc_map.svh ***
// Purpose: Register map, field positions, reset values and timing counts for the request output stage
// Assumes: 200 MHz ref_clk
// Notes:   Definitions only
`ifndef IRQDC_MAP_SVH
`define IRQDC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IRQDC_ADDR_W 10
`define IRQDC_CFG_OFS 10'h054

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IRQDC_DEAS_MSB 31
`define IRQDC_DEAS_LSB 24
`define IRQDC_CLR_BIT 14
`define IRQDC_STS_BIT 13
`define IRQDC_INT_BIT 12
`define IRQDC_EN_BIT 8
`define IRQDC_POL_BIT 4
`define IRQDC_TYPE_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IRQDC_DEAS_RST 8'h00
`define IRQDC_EN_RST 1'h0
`define IRQDC_POL_RST 1'h0
`define IRQDC_TYPE_RST 1'h0
`define IRQDC_ZERO32 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define IRQDC_UNIT_NS 10000
`define IRQDC_CLK_PERIOD_NS 5
`define IRQDC_UNIT_CYC (`IRQDC_UNIT_NS / `IRQDC_CLK_PERIOD_NS)
`define IRQDC_PRE_W 11

`endif

// *** irqdc_pkg.sv ***
// Purpose: Types shared by the request output stage
// Assumes: Nothing beyond the map header
// Notes:   Field widths match the configuration register layout
`default_nettype none

package irqdc_pkg;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [31:0] wdata;
  } irqdc_req_s;

  // ----------------------------------------
  // Stored configuration
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] deassert_interval;
    logic irq_enable;
    logic request_output_polarity;
    logic buffer_push_pull;
  } irqdc_cfg_s;

  typedef enum logic [0:0] {
    IRQDC_PASS,
    IRQDC_HOLD
  } irqdc_state_e;

endpackage : irqdc_pkg

`default_nettype wire

// *** irqdc_top.sv ***
// Purpose: Request output stage: combines enabled sources, applies de-assertion interval, drives request pin
// Assumes: Register port, status, enable and soft reset come from logic on ref_clk
// Notes:   Read data is registered and valid one cycle after the read strobe
//
// Operation
// - An 8-bit interval field in bits 31:24 times the gap between assertions in steps of 10 us.
// - Writing the interval as zero disables it, resets its counter and lets held requests out at once.
// - A new non-zero interval value governs every later de-assertion interval.
// - Writing one to self-clearing bit 14 with a non-zero interval clears the counter and starts a fresh interval; zero does nothing.
// - Bit 13 reads one while an interval runs and requests are withheld from the pin, zero otherwise.
// - Bit 12 shows the internal combined request line, regardless of output enable or interval state.
// - With output enable bit 8 at zero the pin stays de-asserted and internal status is untouched.
// - In push-pull mode polarity bit 4 picks active low at zero and active high at one.
// - Buffer bit 0 picks open-drain at zero and push-pull at one; open-drain is always active low.
// - Polarity and buffer bits survive the soft reset; only the chip reset clears them.
// - The internal request line is the OR of status bits whose enable bits are set.
`include "irqdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module irqdc_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire irqdc_pkg::irqdc_req_s reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [31:0] interrupt_status,
  input wire logic [31:0] interrupt_enable,
  input wire logic soft_reset,
  output logic irq_pin_out,
  output logic irq_pin_oe
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  irqdc_pkg::irqdc_cfg_s cfg_ff;
  irqdc_pkg::irqdc_cfg_s nxt_cfg;
  irqdc_pkg::irqdc_state_e state_ff;
  irqdc_pkg::irqdc_state_e nxt_state;
  logic [`IRQDC_PRE_W-1:0] pre_ff;
  logic [`IRQDC_PRE_W-1:0] nxt_pre;
  logic [7:0] unit_ff;
  logic [7:0] nxt_unit;
  logic asserted_ff;
  logic nxt_asserted;
  logic pin_out_ff;
  logic nxt_pin_out;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic irq_line;
  logic cfg_hit;
  logic wr_hit;
  logic clr_req;
  logic [7:0] wr_interval;
  logic pre_wrap;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    irq_line = |(interrupt_status & interrupt_enable);
    cfg_hit = (reg_req.addr == `IRQDC_CFG_OFS);
    wr_hit = reg_req.wr & cfg_hit;
    wr_interval = reg_req.wdata[`IRQDC_DEAS_MSB:`IRQDC_DEAS_LSB];
    clr_req = wr_hit & reg_req.wdata[`IRQDC_CLR_BIT];
    pre_wrap = (pre_ff == `IRQDC_PRE_W'(`IRQDC_UNIT_CYC - 1));
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_comb begin
    nxt_cfg = cfg_ff;
    if (soft_reset) begin
      // Polarity and buffer type deliberately kept
      nxt_cfg.deassert_interval = `IRQDC_DEAS_RST;
      nxt_cfg.irq_enable = `IRQDC_EN_RST;
    end else if (wr_hit) begin
      nxt_cfg.deassert_interval = wr_interval;
      nxt_cfg.irq_enable = reg_req.wdata[`IRQDC_EN_BIT];
      nxt_cfg.request_output_polarity = reg_req.wdata[`IRQDC_POL_BIT];
      nxt_cfg.buffer_push_pull = reg_req.wdata[`IRQDC_TYPE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff.deassert_interval <= `IRQDC_DEAS_RST;
      cfg_ff.irq_enable <= `IRQDC_EN_RST;
      cfg_ff.request_output_polarity <= `IRQDC_POL_RST;
      cfg_ff.buffer_push_pull <= `IRQDC_TYPE_RST;
    end else if (clk_en) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------
  // De-assertion interval timer
  // ----------------------------------------
  // The limit is read live, so a new value also reshapes an interval already
  // running; the prescaler restarts with each interval so every unit is full.
  always_comb begin
    nxt_state = state_ff;
    nxt_pre = pre_ff;
    nxt_unit = unit_ff;
    if (soft_reset || (wr_hit && (wr_interval == `IRQDC_DEAS_RST))) begin
      nxt_state = irqdc_pkg::IRQDC_PASS;
      nxt_pre = '0;
      nxt_unit = '0;
    end else if (clr_req) begin
      nxt_state = irqdc_pkg::IRQDC_HOLD;
      nxt_pre = '0;
      nxt_unit = '0;
    end else begin
      unique case (state_ff)
        irqdc_pkg::IRQDC_HOLD: begin
          if (cfg_ff.deassert_interval == `IRQDC_DEAS_RST) begin
            nxt_state = irqdc_pkg::IRQDC_PASS;
            nxt_pre = '0;
            nxt_unit = '0;
          end else if (pre_wrap) begin
            nxt_pre = '0;
            if ((unit_ff + 8'h01) >= cfg_ff.deassert_interval) begin
              nxt_state = irqdc_pkg::IRQDC_PASS;
              nxt_unit = '0;
            end else begin
              nxt_unit = unit_ff + 8'h01;
            end
          end else begin
            nxt_pre = pre_ff + `IRQDC_PRE_W'(1);
          end
        end
        irqdc_pkg::IRQDC_PASS: begin
          // Pin falling back to idle opens a new interval
          if (asserted_ff && !(irq_line && cfg_ff.irq_enable) &&
              (cfg_ff.deassert_interval != `IRQDC_DEAS_RST)) begin
            nxt_state = irqdc_pkg::IRQDC_HOLD;
            nxt_pre = '0;
            nxt_unit = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= irqdc_pkg::IRQDC_PASS;
      pre_ff <= '0;
      unit_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      pre_ff <= nxt_pre;
      unit_ff <= nxt_unit;
    end
  end

  // ----------------------------------------
  // Request pin
  // ----------------------------------------
  always_comb begin
    nxt_asserted = irq_line && cfg_ff.irq_enable && (state_ff == irqdc_pkg::IRQDC_PASS);
    if (cfg_ff.buffer_push_pull) begin
      nxt_pin_oe = 1'b1;
      nxt_pin_out = nxt_asserted ? cfg_ff.request_output_polarity : ~cfg_ff.request_output_polarity;
    end else begin
      // Open-drain pulls low only; polarity has no say here
      nxt_pin_oe = nxt_asserted;
      nxt_pin_out = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      asserted_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (clk_en) begin
      asserted_ff <= nxt_asserted;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  always_comb begin
    nxt_rvalid = reg_req.rd;
    nxt_rdata = `IRQDC_ZERO32;
    if (reg_req.rd && cfg_hit) begin
      nxt_rdata[`IRQDC_DEAS_MSB:`IRQDC_DEAS_LSB] = cfg_ff.deassert_interval;
      nxt_rdata[`IRQDC_STS_BIT] = (state_ff == irqdc_pkg::IRQDC_HOLD);
      nxt_rdata[`IRQDC_INT_BIT] = irq_line;
      nxt_rdata[`IRQDC_EN_BIT] = cfg_ff.irq_enable;
      nxt_rdata[`IRQDC_POL_BIT] = cfg_ff.request_output_polarity;
      nxt_rdata[`IRQDC_TYPE_BIT] = cfg_ff.buffer_push_pull;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= `IRQDC_ZERO32;
      rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign irq_pin_out = pin_out_ff;
  assign irq_pin_oe = pin_oe_ff;

endmodule : irqdc_top

`default_nettype wire

// *** irqdc_host.sv ***
// Purpose: Host interrupt input seen across the request pin
// Assumes: Board pull-up on the request wire
// Notes:   A released wire reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module irqdc_host (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic level
);
  // Pull-up takes over only while nobody drives, so open-drain release shows
  assign level = pin_oe ? pin_out : 1'b1;
endmodule : irqdc_host
`default_nettype wire

// *** irqdc_top_chk.sv ***
// Purpose: Port-level checks of the request output stage
// Assumes: One ref_clk domain
// Notes:   Shadows written config to know what the pin level means
`include "irqdc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module irqdc_top_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire irqdc_pkg::irqdc_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [31:0] interrupt_status,
  input wire logic [31:0] interrupt_enable,
  input wire logic soft_reset,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  logic [10:0] sh_ff, nxt_sh, dl_ff;
  logic line, rmap, asrt;
  assign line = |(interrupt_status & interrupt_enable);
  assign rmap = clk_en && reg_req.rd && reg_req.addr == `IRQDC_CFG_OFS;
  always_comb begin
    nxt_sh = sh_ff;
    if (clk_en && soft_reset) begin
      nxt_sh[10:2] = 9'h000;
    end else if (clk_en && reg_req.wr && reg_req.addr == `IRQDC_CFG_OFS) begin
      nxt_sh = {reg_req.wdata[31:24], reg_req.wdata[8], reg_req.wdata[4], reg_req.wdata[0]};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_ff <= 11'h000;
      dl_ff <= 11'h000;
    end else begin
      sh_ff <= nxt_sh;
      dl_ff <= sh_ff;
    end
  end
  // Pin flops lag config by a cycle, hence the delayed shadow
  assign asrt = dl_ff[0] ? (irq_pin_out == dl_ff[1]) : irq_pin_oe;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_UNMAPPED: assert property (clk_en && reg_req.rd && reg_req.addr != `IRQDC_CFG_OFS |=> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  AST_RSVD: assert property (reg_rvalid |-> (reg_rdata & 32'h00FF_CEEE) == 32'h0)
    else $error("reserved or clear bit reads one");
  AST_LINE: assert property (rmap |=> reg_rdata[12] == $past(line))
    else $error("combined line bit wrong");
  AST_EN_OFF: assert property (!dl_ff[2] |-> !asrt)
    else $error("pin asserted while disabled");
  AST_PP: assert property (dl_ff[0] |-> irq_pin_oe)
    else $error("push-pull not driving");
  AST_OD: assert property (!dl_ff[0] |-> !irq_pin_out)
    else $error("open-drain drives high");
  AST_NEEDS: assert property (asrt |-> $past(line) || $past(line, 2))
    else $error("pin asserted without request");
  AST_HOLD: assert property ($fell(asrt) && dl_ff[10:3] != 8'h00 |=> !asrt [*8])
    else $error("no hold after release");
endmodule : irqdc_top_chk
bind irqdc_top irqdc_top_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .interrupt_status(interrupt_status),
  .interrupt_enable(interrupt_enable), .soft_reset(soft_reset), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the request output stage
// Assumes: 200 MHz ref_clk, interval unit of 2000 cycles
// Notes:   Reads queue expected words; a monitor compares each answer
`include "irqdc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst_b, clk_en, srst, rvalid, pout, poe, lvl;
  irqdc_pkg::irqdc_req_s req;
  logic [31:0] rdata, st, en, r;
  logic [15:0] rs;
  logic [31:0] expq[$];
  int mismatches, cmp_count, n;
  irqdc_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .interrupt_status(st), .interrupt_enable(en), .soft_reset(srst), .irq_pin_out(pout),
    .irq_pin_oe(poe));
  irqdc_host u_host (.pin_out(pout), .pin_oe(poe), .level(lvl));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Flags are {enable, polarity, push-pull, line, active}
  function automatic logic [31:0] cv(input logic [7:0] iv, input logic [4:0] f);
    cv = {iv, 10'h000, f[0], f[1], 3'h0, f[4], 3'h0, f[3], 3'h0, f[2]};
  endfunction : cv
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [31:0] d);
    req.wr = 1'b1;
    req.addr = `IRQDC_CFG_OFS;
    req.wdata = d;
    cyc(1);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    expq.push_back(e);
    req.rd = 1'b1;
    req.addr = a;
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
  endtask : rd
  // Random sources; only bit 0 overlaps its enable, so the line is exact
  task automatic line(input logic on);
    rs = lfsr(rs);
    r = {rs, ~rs};
    st = on ? (r | 32'h0000_0001) : (r & 32'hFFFF_FFFE);
    en = ~r | 32'h0000_0001;
  endtask : line
  task automatic pin(input logic e);
    chk({31'h0, lvl}, {31'h0, e});
  endtask : pin
  task automatic wt(input logic e, input int lim);
    n = 0;
    while (lvl !== e && n < lim) begin
      cyc(1);
      n++;
    end
    pin(e);
    if (n >= lim) test_done();
  endtask : wt
  // Answers are looked at mid-cycle, where the registered read data has settled
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1) begin
      chk(rdata, expq.size() > 0 ? expq.pop_front() : 32'hFFFF_FFFF);
    end
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    srst = 1'b0;
    req = '0;
    st = 32'h0;
    en = 32'h0;
    rs = 16'h08DF;
    cyc(3);
    rst_b = 1'b1;
    rd(`IRQDC_CFG_OFS, 32'h0);
    rd(10'h058, 32'h0);
    line(1'b1);
    wr(cv(8'h01, 5'h1C));
    cyc(3);
    pin(1'b1);
    line(1'b0);
    cyc(3);
    pin(1'b0);
    line(1'b1);
    cyc(1800);
    pin(1'b0);
    rd(`IRQDC_CFG_OFS, cv(8'h01, 5'h1F));
    wt(1'b1, 400);
    line(1'b0);
    cyc(1000);
    wr(cv(8'h01, 5'h1C) | 32'h0000_4000);
    line(1'b1);
    cyc(1500);
    pin(1'b0);
    wr(cv(8'h00, 5'h1C));
    cyc(3);
    pin(1'b1);
    wr(cv(8'h02, 5'h1C));
    line(1'b0);
    cyc(3);
    line(1'b1);
    cyc(3000);
    pin(1'b0);
    wt(1'b1, 1200);
    wr(cv(8'h00, 5'h10));
    cyc(3);
    pin(1'b0);
    wr(cv(8'h00, 5'h18));
    cyc(3);
    pin(1'b0);
    wr(cv(8'h00, 5'h08));
    cyc(3);
    pin(1'b1);
    rd(`IRQDC_CFG_OFS, cv(8'h00, 5'h0A));
    wr(cv(8'h03, 5'h0C));
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    rd(`IRQDC_CFG_OFS, cv(8'h00, 5'h0E));
    cyc(2);
    chk(32'(expq.size()), 32'h0000_0000);
    test_done();
  end
endmodule : tb
`default_nettype wire
